/* File: pkg/adcseq_pkg.sv */
`default_nettype none
package adcseq_pkg;

    // =====================================================
    // Register map, word addressed
    localparam logic [0:0] CMD_ADDR = 1'h0;

    // =====================================================
    // Command register fields
    localparam int RUN_BIT = 0;
    localparam int MODE_LSB = 1;
    localparam int MODE_MSB = 3;
    localparam int RSVD_LSB = 4;
    localparam logic RUN_RESET = 1'h0;
    localparam logic [2:0] MODE_RESET = 3'h0;

    // =====================================================
    // Mode codes, 2 to 6 are reserved
    localparam logic [2:0] MODE_CONT = 3'h0;
    localparam logic [2:0] MODE_SINGLE = 3'h1;
    localparam logic [2:0] MODE_RECAL = 3'h7;

    // =====================================================
    // Channel codes
    localparam logic [4:0] CH_FIRST = 5'h00;
    localparam logic [4:0] CH_LAST = 5'h11;
    localparam logic [4:0] CH_RECAL = 5'h1F;

    // =====================================================
    // Types
    typedef struct packed {
        logic [4:0] channel;
        logic sop;
        logic eop;
    } adcseq_cmd_s;

    typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} adcseq_state_e;

endpackage : adcseq_pkg
`default_nettype wire

/* File: pkg/adcseq_cmd_if.sv */
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// Command beat stream between sequencer and buffer
interface adcseq_cmd_if;
    logic valid;
    logic ready;
    adcseq_pkg::adcseq_cmd_s beat;

    modport src (output valid, output beat, input ready);
    modport snk (input valid, input beat, output ready);
endinterface : adcseq_cmd_if
`default_nettype wire

/* File: hw/adcseq_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// Two-flop level synchroniser
module adcseq_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rstN,
    // Level
    input wire logic asyncIn,
    output logic syncOut
);
    import adcseq_pkg::*;

    typedef struct packed {
        logic meta;
        logic stable;
    } adcseq_sync_s;

    adcseq_sync_s r_reg;
    adcseq_sync_s r_next;

    // First stage feeds only the second
    always_comb begin
        r_next.meta = asyncIn;
        r_next.stable = r_reg.meta;
    end

    // Registers
    always_ff @(posedge clk) begin
        if (!rstN) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign syncOut = r_reg.stable;
endmodule : adcseq_sync
`default_nettype wire

/* File: hw/adcseq_buf2.sv */
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// Two-entry buffer, head output straight from a flop
module adcseq_buf2 (
    // Clock and reset
    input wire logic clk,
    input wire logic rstN,
    // Filling side
    adcseq_cmd_if.snk inPort,
    // Draining side
    output logic outValid,
    input wire logic outReady,
    output adcseq_pkg::adcseq_cmd_s outBeat
);
    import adcseq_pkg::*;

    typedef struct packed {
        logic headV;
        adcseq_cmd_s head;
        logic tailV;
        adcseq_cmd_s tail;
    } adcseq_buf_s;

    adcseq_buf_s r_reg;
    adcseq_buf_s r_next;

    // Room while the second entry is free
    assign inPort.ready = !r_reg.tailV;

    // Pop first, then push into the first free entry
    always_comb begin
        r_next = r_reg;
        if (r_reg.headV && outReady) begin
            r_next.head = r_reg.tail;
            r_next.headV = r_reg.tailV;
            r_next.tailV = 1'b0;
        end
        if (inPort.valid && !r_reg.tailV) begin
            if (!r_next.headV) begin
                r_next.head = inPort.beat;
                r_next.headV = 1'b1;
            end else begin
                r_next.tail = inPort.beat;
                r_next.tailV = 1'b1;
            end
        end
    end

    // Registers
    always_ff @(posedge clk) begin
        if (!rstN) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign outValid = r_reg.headV;
    assign outBeat = r_reg.head;
endmodule : adcseq_buf2
`default_nettype wire

/* File: hw/adcseq_top.sv */
// What this block does
// - Threshold stream has valid but no ready
// - Beat carries 5-bit channel, 17 is temperature
// - Beat data 1 above max, 0 below min
// - Slave port: read/write strobes, 32-bit data
// - Word addressing, sequencer decodes one address bit
// - One interrupt request output
// - Single peripheral clock for all logic
// - Single reset clears everything together
// - Mode field bits 3:1, reset zero
// - Mode writes ignored while running
// - Bit 0 run control, reset zero
`timescale 1ns/10ps
`default_nettype none
module adcseq_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rstN,
    // Register port
    input wire logic [0:0] csrAddress,
    input wire logic csrRead,
    input wire logic csrWrite,
    input wire logic [31:0] csrWriteData,
    output logic [31:0] csrReadData,
    // Interrupt
    input wire logic storeIrq,
    output logic irq,
    // Converter clock lock
    input wire logic pllLocked,
    // Hard block command stream
    output logic hbCmdValid,
    input wire logic hbCmdReady,
    output logic [4:0] hbCmdChannel,
    output logic hbCmdSop,
    output logic hbCmdEop,
    // Hard block response stream
    input wire logic hbRspValid,
    input wire logic [4:0] hbRspChannel,
    input wire logic [11:0] hbRspData,
    input wire logic hbRspEop,
    // Threshold limits
    input wire logic [11:0] limitMax,
    input wire logic [11:0] limitMin,
    // Threshold violation stream
    output logic thrValid,
    output logic [4:0] thrChannel,
    output logic thrData,
    // Sample store write
    output logic smpValid,
    output logic [5:0] smpSlot,
    output logic [11:0] smpData,
    // Status
    output logic seqBusy
);
    import adcseq_pkg::*;

    // =====================================================
    // State
    typedef struct packed {
        adcseq_state_e state;
        logic run;
        logic [2:0] mode;
        logic stopPend;
        logic [4:0] slot;
        logic [5:0] rspSlot;
        logic [31:0] readData;
        logic thrValid;
        logic [4:0] thrChannel;
        logic thrData;
        logic smpValid;
        logic [5:0] smpSlot;
        logic [11:0] smpData;
        logic irq;
        logic busy;
    } adcseq_top_s;

    adcseq_top_s r_reg;
    adcseq_top_s r_next;

    logic lockedSync;
    logic issueValid;
    adcseq_cmd_s issueBeat;
    logic cmdTaken;
    logic seqDone;
    logic cmdSel;
    adcseq_cmd_s hbBeat;

    adcseq_cmd_if cmdIf ();

    // =====================================================
    // Lock input crossing
    adcseq_sync u_lockSync (
        .clk(clk),
        .rstN(rstN),
        .asyncIn(pllLocked),
        .syncOut(lockedSync)
    );

    // =====================================================
    // Command buffer toward the hard block
    adcseq_buf2 u_cmdBuf (
        .clk(clk),
        .rstN(rstN),
        .inPort(cmdIf),
        .outValid(hbCmdValid),
        .outReady(hbCmdReady),
        .outBeat(hbBeat)
    );

    assign hbCmdChannel = hbBeat.channel;
    assign hbCmdSop = hbBeat.sop;
    assign hbCmdEop = hbBeat.eop;

    // =====================================================
    // Command beat built from the slot counter, or fixed to CH_RECAL in recal mode
    always_comb begin
        issueValid = (r_reg.state == ST_ISSUE);
        if (r_reg.mode == MODE_RECAL) begin
            issueBeat.channel = CH_RECAL;
            issueBeat.sop = 1'b1;
            issueBeat.eop = 1'b1;
        end else begin
            issueBeat.channel = r_reg.slot;
            issueBeat.sop = (r_reg.slot == CH_FIRST);
            issueBeat.eop = (r_reg.slot == CH_LAST);
        end
    end

    assign cmdIf.valid = issueValid;
    assign cmdIf.beat = issueBeat;
    assign cmdTaken = issueValid && cmdIf.ready;
    assign seqDone = (r_reg.state == ST_WAIT) && hbRspValid && hbRspEop;
    assign cmdSel = (csrAddress == CMD_ADDR);

    // =====================================================
    // Next-state logic
    always_comb begin
        r_next = r_reg;
        r_next.thrValid = 1'b0;
        r_next.smpValid = 1'b0;

        // Register read, one cycle latency
        if (csrRead) begin
            r_next.readData = 32'h0000_0000;
            if (cmdSel) begin
                r_next.readData[MODE_MSB:MODE_LSB] = r_reg.mode;
                r_next.readData[RUN_BIT] = r_reg.run;
            end
        end

        // Sequencer
        unique case (r_reg.state)
            ST_IDLE: begin
                if (r_reg.run && lockedSync) begin
                    if (r_reg.mode == MODE_CONT || r_reg.mode == MODE_SINGLE
                        || r_reg.mode == MODE_RECAL) begin
                        r_next.state = ST_ISSUE;
                        r_next.slot = CH_FIRST;
                        r_next.rspSlot = 6'h00;
                    end else begin
                        r_next.run = 1'b0; // Reserved mode never starts
                    end
                end
            end
            ST_ISSUE: begin
                if (cmdTaken) begin
                    if (issueBeat.eop) begin
                        r_next.state = ST_WAIT;
                    end else begin
                        r_next.slot = r_reg.slot + 5'h01;
                    end
                end
            end
            ST_WAIT: begin
                if (seqDone) begin
                    if (r_reg.mode == MODE_CONT && !r_reg.stopPend) begin
                        r_next.state = ST_ISSUE;
                        r_next.slot = CH_FIRST;
                        r_next.rspSlot = 6'h00;
                    end else begin
                        r_next.state = ST_IDLE;
                        r_next.run = 1'b0;
                        r_next.stopPend = 1'b0;
                    end
                end
            end
        endcase

        // Sample slots refill from zero on every pass
        if (hbRspValid && r_reg.state != ST_IDLE && r_reg.mode != MODE_RECAL) begin
            r_next.smpValid = 1'b1;
            r_next.smpSlot = r_reg.rspSlot;
            r_next.smpData = hbRspData;
            r_next.rspSlot = r_reg.rspSlot + 6'h01;
            if (seqDone) begin
                r_next.rspSlot = 6'h00;
            end
        end

        // Threshold check on each analog or temperature result
        if (hbRspValid && hbRspChannel <= CH_LAST && r_reg.mode != MODE_RECAL) begin
            if (hbRspData > limitMax) begin
                r_next.thrValid = 1'b1;
                r_next.thrChannel = hbRspChannel;
                r_next.thrData = 1'b1;
            end else if (hbRspData < limitMin) begin
                r_next.thrValid = 1'b1;
                r_next.thrChannel = hbRspChannel;
                r_next.thrData = 1'b0;
            end
        end

        // Command register write
        if (csrWrite && cmdSel) begin
            if (!r_reg.run) begin
                r_next.mode = csrWriteData[MODE_MSB:MODE_LSB];
            end
            if (csrWriteData[RUN_BIT]) begin
                if (r_reg.state == ST_IDLE) begin
                    r_next.run = 1'b1;
                end
                r_next.stopPend = 1'b0;
            end else if (r_reg.state == ST_IDLE) begin
                r_next.run = 1'b0;
            end else begin
                // Also when the pass ends now, so a continuous restart still stops
                r_next.stopPend = 1'b1;
            end
        end

        // Interrupt and status, registered
        r_next.irq = storeIrq;
        r_next.busy = (r_next.state != ST_IDLE);
    end

    // =====================================================
    // Registers, one clock, one active-low synchronous reset
    always_ff @(posedge clk) begin
        if (!rstN) begin
            r_reg <= '0;
            r_reg.state <= ST_IDLE;
            r_reg.run <= RUN_RESET;
            r_reg.mode <= MODE_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // =====================================================
    // Outputs
    assign csrReadData = r_reg.readData;
    assign irq = r_reg.irq;
    assign thrValid = r_reg.thrValid;
    assign thrChannel = r_reg.thrChannel;
    assign thrData = r_reg.thrData;
    assign smpValid = r_reg.smpValid;
    assign smpSlot = r_reg.smpSlot;
    assign smpData = r_reg.smpData;
    assign seqBusy = r_reg.busy;
endmodule : adcseq_top
`default_nettype wire

/* File: dv/adcseq_hb_model.sv */
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// Converter hard block stand-in
module adcseq_hb_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rstN,
    // Command side
    input wire logic hbCmdValid,
    output logic hbCmdReady,
    input wire logic [4:0] hbCmdChannel,
    input wire logic hbCmdEop,
    input wire logic stall,
    // Response side
    output logic hbRspValid,
    output logic [4:0] hbRspChannel,
    output logic [11:0] hbRspData,
    output logic hbRspEop
);
    // Ready toggles while stalling, answer one cycle after a take
    always @(posedge clk) begin
        if (!rstN) begin
            hbCmdReady <= 1'b0;
            hbRspValid <= 1'b0;
            hbRspChannel <= 5'h00;
            hbRspData <= 12'h000;
            hbRspEop <= 1'b0;
        end else begin
            hbCmdReady <= !stall || !hbCmdReady;
            hbRspValid <= hbCmdValid && hbCmdReady;
            // Idle lines keep moving so stale values never pass
            if (hbCmdValid && hbCmdReady) begin
                hbRspChannel <= hbCmdChannel;
                hbRspData <= hbCmdChannel * 12'h0F0;
                hbRspEop <= hbCmdEop;
            end else begin
                hbRspChannel <= ~hbRspChannel;
                hbRspData <= ~hbRspData;
                hbRspEop <= 1'b0;
            end
        end
    end
endmodule : adcseq_hb_model
`default_nettype wire

/* File: dv/adcseq_checker.sv */
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// Port checker
module adcseq_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rstN,
    // Register port
    input wire logic [0:0] csrAddress,
    input wire logic csrRead,
    input wire logic csrWrite,
    input wire logic [31:0] csrWriteData,
    input wire logic [31:0] csrReadData,
    input wire logic storeIrq,
    input wire logic irq,
    // Streams
    input wire logic hbCmdValid,
    input wire logic hbCmdReady,
    input wire logic [4:0] hbCmdChannel,
    input wire logic hbCmdSop,
    input wire logic hbRspValid,
    input wire logic [4:0] hbRspChannel,
    input wire logic [11:0] hbRspData,
    input wire logic hbRspEop,
    input wire logic [11:0] limitMax,
    input wire logic [11:0] limitMin,
    input wire logic thrValid,
    input wire logic [4:0] thrChannel,
    input wire logic thrData,
    input wire logic seqBusy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstN);
    // Responses that must raise a violation beat, and a stop write
    sequence rspHigh;
        hbRspValid && hbRspChannel <= 5'h11 && hbRspData > limitMax;
    endsequence
    sequence rspLow;
        hbRspValid && hbRspChannel <= 5'h11 && hbRspData < limitMin;
    endsequence
    sequence stopWrite;
        csrWrite && csrAddress == 1'h0 && !csrWriteData[0];
    endsequence
    thr_above_a: assert property (
        rspHigh |=> thrValid && thrData && thrChannel == $past(hbRspChannel))
        else $error("no above-max beat");
    thr_below_a: assert property (
        rspLow |=> thrValid && !thrData && thrChannel == $past(hbRspChannel))
        else $error("no below-min beat");
    thr_quiet_a: assert property (
        !hbRspValid || hbRspChannel > 5'h11 |=> !thrValid)
        else $error("beat without cause");
    irq_copy_a: assert property (storeIrq |=> irq)
        else $error("irq not raised");
    rsvd_zero_a: assert property (csrRead |=> csrReadData[31:4] == 28'h0)
        else $error("reserved bits not zero");
    unmapped_a: assert property (
        csrRead && csrAddress == 1'h1 |=> csrReadData == 32'h0)
        else $error("unmapped read not zero");
    stop_wait_a: assert property (
        seqBusy && !(hbRspValid && hbRspEop) && !$past(hbRspValid && hbRspEop)
        ##0 stopWrite |=> seqBusy)
        else $error("stop cut a sequence");
    sop_first_a: assert property (
        hbCmdValid && hbCmdSop |-> hbCmdChannel == 5'h00 || hbCmdChannel == 5'h1F)
        else $error("sequence not at slot 0");
    cmd_hold_a: assert property (
        hbCmdValid && !hbCmdReady |=> hbCmdValid && $stable(hbCmdChannel))
        else $error("stalled beat lost");
    reset_idle_a: assert property (
        disable iff (1'b0) !rstN |=> !thrValid && !seqBusy && !hbCmdValid && !irq)
        else $error("outputs not idle in reset");
endmodule : adcseq_checker
bind adcseq_top adcseq_checker chk_u (
    .clk, .rstN, .csrAddress, .csrRead, .csrWrite, .csrWriteData, .csrReadData,
    .storeIrq, .irq, .hbCmdValid, .hbCmdReady, .hbCmdChannel, .hbCmdSop,
    .hbRspValid, .hbRspChannel, .hbRspData, .hbRspEop, .limitMax, .limitMin,
    .thrValid, .thrChannel, .thrData, .seqBusy
);
`default_nettype wire

/* File: dv/tb_adc_sequencer_csr_interfaces.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_adc_sequencer_csr_interfaces;
    logic clk = 1'b0;
    logic rstN = 1'b0;
    logic [0:0] csrAddress = 1'h0;
    logic csrRead = 1'b0;
    logic csrWrite = 1'b0;
    logic [31:0] csrWriteData = 32'h0;
    logic [31:0] csrReadData;
    logic storeIrq = 1'b0;
    logic pllLocked = 1'b0;
    logic stall = 1'b0;
    logic irq, hbCmdValid, hbCmdReady, hbCmdSop, hbCmdEop, hbRspValid, hbRspEop;
    logic thrValid, thrData, smpValid, seqBusy;
    logic [4:0] hbCmdChannel, hbRspChannel, thrChannel;
    logic [11:0] hbRspData;
    logic [5:0] smpSlot;
    logic [11:0] smpData;
    int num_errors = 0;
    int total_checks = 0;
    int nBeats, nAbove, nBelow, nSmp;

    always #25 clk = ~clk;

    adcseq_top dut_u (
        .clk, .rstN, .csrAddress, .csrRead, .csrWrite, .csrWriteData, .csrReadData,
        .storeIrq, .irq, .pllLocked, .hbCmdValid, .hbCmdReady, .hbCmdChannel,
        .hbCmdSop, .hbCmdEop, .hbRspValid, .hbRspChannel, .hbRspData, .hbRspEop,
        .limitMax(12'h800), .limitMin(12'h100), .thrValid, .thrChannel, .thrData,
        .smpValid, .smpSlot, .smpData, .seqBusy
    );
    adcseq_hb_model hb_u (
        .clk, .rstN, .hbCmdValid, .hbCmdReady, .hbCmdChannel, .hbCmdEop, .stall,
        .hbRspValid, .hbRspChannel, .hbRspData, .hbRspEop
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [0:0] a, input logic [31:0] d);
        @(posedge clk);
        csrAddress <= a;
        csrWriteData <= d;
        csrWrite <= 1'b1;
        @(posedge clk);
        csrWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [0:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        csrAddress <= a;
        csrRead <= 1'b1;
        @(posedge clk);
        csrRead <= 1'b0;
        @(negedge clk);
        check(what, csrReadData, exp);
    endtask : rd
    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (seqBusy !== lvl && n < 2000) begin
            @(negedge clk);
            n++;
        end
        check("busy level", {31'h0, seqBusy}, {31'h0, lvl});
    endtask : wait_busy
    task automatic clr(input string name);
        $display("test %s done", name);
        nBeats = 0;
        nAbove = 0;
        nBelow = 0;
        nSmp = 0;
    endtask : clr
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    // Count traffic; every violation beat is taken at once
    always @(posedge clk) begin
        if (rstN) begin
            if (hbCmdValid && hbCmdReady) nBeats++;
            // Slots follow channels in order, data is channel times 0xF0
            if (smpValid) begin
                check("sample slot", {26'h0, smpSlot}, nSmp % 18);
                check("sample data", {20'h0, smpData}, (nSmp % 18) * 240);
                nSmp++;
            end
            if (thrValid) begin
                if (thrData) nAbove++;
                else nBelow++;
                check("violation type", {31'h0, thrData}, {31'h0, thrChannel >= 5'h09});
            end
        end
    end

    // Hang guard
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        end_of_test();
    end

    // Test sequence
    initial begin
        repeat (20) @(posedge clk);
        rstN <= 1'b1;
        rd(1'h0, 32'h0, "cmd reset");
        wr(1'h1, 32'hFFFF_FFFF);
        rd(1'h1, 32'h0, "unmapped");
        rd(1'h0, 32'h0, "cmd after unmapped");
        for (int m = 0; m < 8; m++) begin
            wr(1'h0, {28'hFFFFFFF, m[2:0], 1'b0});
            rd(1'h0, {28'h0, m[2:0], 1'b0}, "mode code");
        end
        @(posedge clk);
        storeIrq <= 1'b1;
        @(posedge clk);
        storeIrq <= 1'b0;
        @(negedge clk);
        check("irq raised", {31'h0, irq}, 32'h1);
        @(negedge clk);
        check("irq dropped", {31'h0, irq}, 32'h0);
        clr("registers");
        // Single pass with a stalling hard block
        @(posedge clk);
        pllLocked <= 1'b1;
        stall <= 1'b1;
        wr(1'h0, 32'h3);
        wait_busy(1'b1);
        wr(1'h0, 32'hF);
        rd(1'h0, 32'h3, "mode locked");
        wait_busy(1'b0);
        rd(1'h0, 32'h2, "single ends");
        check("beats", nBeats, 18);
        check("below", nBelow, 2);
        check("above", nAbove, 9);
        check("samples", nSmp, 18);
        clr("single");
        // Continuous, stop asked in the second pass
        @(posedge clk);
        stall <= 1'b0;
        wr(1'h0, 32'h1);
        for (int n = 0; n < 200 && nBeats < 22; n++) @(posedge clk);
        wr(1'h0, 32'h0);
        rd(1'h0, 32'h1, "stop pending");
        wait_busy(1'b0);
        rd(1'h0, 32'h0, "stopped");
        check("restart beats", nBeats, 36);
        check("restart samples", nSmp, 36);
        clr("continuous");
        // Recalibration and a reserved mode
        wr(1'h0, 32'hF);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rd(1'h0, 32'hE, "recal ends");
        check("recal beats", nBeats, 1);
        check("recal flags", nAbove + nBelow, 0);
        clr("recal");
        wr(1'h0, 32'h5);
        rd(1'h1, 32'h0, "unmapped again");
        rd(1'h0, 32'h4, "reserved mode");
        check("reserved beats", nBeats, 0);
        clr("reserved");
        end_of_test();
    end
endmodule : tb_adc_sequencer_csr_interfaces
`default_nettype wire
